// ==== cdl_defines.vh ====
// Purpose: Shared constants of the charge level indicator block.
// Assumes: Included by its bare name from every file that uses its constants.
// Notes:   Offsets are byte addresses on the AHB-Lite register bus.
`ifndef CDL_DEFINES_VH
`define CDL_DEFINES_VH

// ======================================================================
// Register offsets
`define CDL_ADDR_CFG 8'h00
`define CDL_ADDR_CHARGE 8'h04
`define CDL_ADDR_HOLD 8'h08
`define CDL_ADDR_TEST 8'h0C
`define CDL_ADDR_STATUS 8'h10

// ======================================================================
// Field positions, reset values and limits
`define CDL_CFG_MODE_MSB 2
`define CDL_CFG_ON_BIT 3
`define CDL_CFG_CNT_LSB 4
`define CDL_CFG_CNT_MSB 7
`define CDL_CFG_RST 8'h00
`define CDL_CHARGE_RST 7'h00
`define CDL_HOLD_RST 8'h04
`define CDL_TEST_FORCE_BIT 0
`define CDL_TEST_VAL_BIT 1
`define CDL_CHARGE_MAX 7'h64
`define CDL_SINGLE_MAX 7'h5A

// ======================================================================
// Display modes
`define CDL_MODE_NONE 3'h0
`define CDL_MODE_ONE 3'h1
`define CDL_MODE_FOUR 3'h2
`define CDL_MODE_EXT_2W 3'h3
`define CDL_MODE_EXT_1W 3'h4

// ======================================================================
// Timing
`define CDL_CLK_PERIOD_NS 8
`define CDL_TICK_MS 10
`define CDL_TICK_CYC (`CDL_TICK_MS * 1000000 / `CDL_CLK_PERIOD_NS)
`define CDL_PERIOD_MS 1000
`define CDL_TICKS_PER_SEC (`CDL_PERIOD_MS / `CDL_TICK_MS)
`define CDL_HOLD_MIN_MS 1500
`define CDL_HOLD_MIN_TICKS (`CDL_HOLD_MIN_MS / `CDL_TICK_MS)
`define CDL_SHIFT_HALF_NS 64
`define CDL_SHIFT_HALF_CYC (`CDL_SHIFT_HALF_NS / `CDL_CLK_PERIOD_NS)

`endif

// ==== cdl_sync2.v ====
// Purpose: Two flip-flop synchroniser for one level from outside.
// Assumes: The input is a slow level from a pin.
// Notes:   The first stage feeds only the second stage.
module cdl_sync2 (
    input wire clk,
    input wire arst_n,
    input wire din,
    output reg dout
);
    reg meta_reg;

    // ==================================================================
    // Synchroniser
    always @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            meta_reg <= 1'b0;
            dout <= 1'b0;
        end else begin
            meta_reg <= din;
            dout <= meta_reg;
        end
    end
endmodule

// ==== cdl_display.v ====
// Purpose: Charge level display on one to sixteen indicator LEDs.
// Assumes: AHB-Lite slave, single word transfers, 125 MHz sys_clk.
// Notes:   Outputs are active high and all come from flip-flops.
`include "cdl_defines.vh"
module cdl_display #(
    parameter TICK_CYC = `CDL_TICK_CYC,
    parameter SHIFT_HALF = `CDL_SHIFT_HALF_CYC
) (
    input wire sys_clk,
    input wire arst_n,
    input wire hsel,
    input wire [31:0] haddr,
    input wire [1:0] htrans,
    input wire hwrite,
    input wire [2:0] hsize,
    input wire [31:0] hwdata,
    input wire hready,
    output reg hreadyout,
    output reg [31:0] hrdata,
    output reg hresp,
    input wire display_request_sense,
    output reg port_c_bit2_out,
    output reg port_c_bit0_out,
    output reg port_a_bit1_out,
    output reg port_a_bit2_out
);
    localparam SH_IDLE = 2'h0;
    localparam SH_LOW = 2'h1;
    localparam SH_HIGH = 2'h2;

    reg [7:0] cfg_reg;
    reg [6:0] charge_reg;
    reg [7:0] hold_reg;
    reg [1:0] test_reg;
    reg wr_pend_reg;
    reg [7:0] wr_addr_reg;
    reg [31:0] tick_cnt_reg;
    reg [6:0] cs_cnt_reg;
    reg [7:0] press_cnt_reg;
    reg showing_reg;
    reg [7:0] sec_left_reg;
    reg [6:0] snap_reg;
    reg [1:0] sh_state_reg;
    reg [31:0] half_cnt_reg;
    reg [3:0] idx_reg;
    reg [15:0] sh_pat_reg;
    reg [15:0] shifted_reg;
    reg sclk_reg;
    reg sdata_reg;
    reg [31:0] rd_next;
    reg [15:0] ext_pat;
    reg [15:0] want_pat;
    reg [3:0] pins_next;
    wire req_sync;
    wire [2:0] mode;
    wire always_on;
    wire ext_mode;
    wire [4:0] led_n;
    wire [11:0] prod;
    wire [31:0] prod_ext;
    wire [31:0] n_ext;
    wire tick;
    wire sec_tick;
    wire press_fire;
    wire [6:0] single_lim;
    wire [7:0] hold_eff;
    wire take;
    integer i;

    // ==================================================================
    // Request input synchroniser
    cdl_sync2 u_req_sync (
        .clk(sys_clk),
        .arst_n(arst_n),
        .din(display_request_sense),
        .dout(req_sync)
    );

    // ==================================================================
    // Configuration decode
    assign mode = cfg_reg[`CDL_CFG_MODE_MSB:0];
    assign ext_mode = (mode == `CDL_MODE_EXT_2W) ||
                      (mode == `CDL_MODE_EXT_1W);
    assign always_on = cfg_reg[`CDL_CFG_ON_BIT] &&
                       (mode != `CDL_MODE_ONE) &&
                       (mode != `CDL_MODE_NONE);
    assign led_n = {1'b0, cfg_reg[`CDL_CFG_CNT_MSB:`CDL_CFG_CNT_LSB]} +
                   5'h01;
    assign hold_eff = (hold_reg == 8'h00) ? 8'h01 : hold_reg;

    // ==================================================================
    // AHB-Lite slave
    assign take = hsel && hready && htrans[1];

    always @* begin
        case (haddr[7:0])
            `CDL_ADDR_CFG: rd_next = {24'h000000, cfg_reg};
            `CDL_ADDR_CHARGE: rd_next = {25'h0000000, charge_reg};
            `CDL_ADDR_HOLD: rd_next = {24'h000000, hold_reg};
            `CDL_ADDR_TEST: rd_next = {30'h00000000, test_reg};
            `CDL_ADDR_STATUS: rd_next = {shifted_reg, 4'h0, pins_next,
                                         5'h00, req_sync,
                                         (sh_state_reg != SH_IDLE),
                                         showing_reg};
            default: rd_next = 32'h00000000;
        endcase
    end

    always @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            hreadyout <= 1'b1;
            hresp <= 1'b0;
            hrdata <= 32'h00000000;
            wr_pend_reg <= 1'b0;
            wr_addr_reg <= 8'h00;
            cfg_reg <= `CDL_CFG_RST;
            charge_reg <= `CDL_CHARGE_RST;
            hold_reg <= `CDL_HOLD_RST;
            test_reg <= 2'h0;
        end else begin
            if (wr_pend_reg) begin
                case (wr_addr_reg)
                    `CDL_ADDR_CFG: cfg_reg <= hwdata[7:0];
                    `CDL_ADDR_CHARGE: begin
                        if (hwdata[6:0] > `CDL_CHARGE_MAX) begin
                            charge_reg <= `CDL_CHARGE_MAX;
                        end else begin
                            charge_reg <= hwdata[6:0];
                        end
                    end
                    `CDL_ADDR_HOLD: hold_reg <= hwdata[7:0];
                    `CDL_ADDR_TEST: test_reg <= hwdata[1:0];
                    default: test_reg <= test_reg;
                endcase
            end
            wr_pend_reg <= take && hwrite;
            wr_addr_reg <= haddr[7:0];
            if (take && !hwrite) begin
                hrdata <= rd_next;
            end
        end
    end

    // ==================================================================
    // Time base: 10 ms ticks and one second period
    assign tick = (tick_cnt_reg == TICK_CYC - 1);
    assign sec_tick = tick && (cs_cnt_reg == `CDL_TICKS_PER_SEC - 1);

    always @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            tick_cnt_reg <= 32'h00000000;
            cs_cnt_reg <= 7'h00;
        end else begin
            tick_cnt_reg <= tick ? 32'h00000000 : tick_cnt_reg + 32'h1;
            if (sec_tick) begin
                cs_cnt_reg <= 7'h00;
            end else if (tick) begin
                cs_cnt_reg <= cs_cnt_reg + 7'h01;
            end
        end
    end

    // ==================================================================
    // Button hold detection and display sequence
    assign press_fire = tick && req_sync &&
                        (press_cnt_reg == `CDL_HOLD_MIN_TICKS - 1);

    always @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            press_cnt_reg <= 8'h00;
            showing_reg <= 1'b0;
            sec_left_reg <= 8'h00;
            snap_reg <= 7'h00;
        end else begin
            if (!req_sync) begin
                press_cnt_reg <= 8'h00;
            end else if (tick && press_cnt_reg != `CDL_HOLD_MIN_TICKS) begin
                press_cnt_reg <= press_cnt_reg + 8'h01;
            end
            if (always_on) begin
                showing_reg <= 1'b1;
                if (!showing_reg || (sec_tick && sec_left_reg <= 8'h01)) begin
                    sec_left_reg <= hold_eff;
                    snap_reg <= charge_reg;
                end else if (sec_tick) begin
                    sec_left_reg <= sec_left_reg - 8'h01;
                end
            end else if (press_fire && mode != `CDL_MODE_NONE) begin
                showing_reg <= 1'b1;
                sec_left_reg <= hold_eff;
                snap_reg <= charge_reg;
            end else if (showing_reg && sec_tick) begin
                if (sec_left_reg <= 8'h01) begin
                    showing_reg <= 1'b0;
                end
                sec_left_reg <= sec_left_reg - 8'h01;
            end
        end
    end

    // ==================================================================
    // Display patterns
    assign single_lim = (snap_reg > `CDL_SINGLE_MAX) ?
                        `CDL_SINGLE_MAX : snap_reg;
    assign prod = snap_reg * {2'h0, led_n};
    assign prod_ext = {20'h00000, prod};
    assign n_ext = {27'h0000000, led_n};

    always @* begin
        for (i = 0; i < 16; i = i + 1) begin
            ext_pat[i] = (i < n_ext) && (prod_ext > i * 100);
        end
        if (test_reg[`CDL_TEST_FORCE_BIT]) begin
            for (i = 0; i < 16; i = i + 1) begin
                want_pat[i] = (i < n_ext) &&
                              test_reg[`CDL_TEST_VAL_BIT];
            end
        end else if (showing_reg) begin
            want_pat = ext_pat;
        end else begin
            want_pat = 16'h0000;
        end
    end

    always @* begin
        pins_next = 4'h0;
        if (test_reg[`CDL_TEST_FORCE_BIT] && !ext_mode) begin
            if (mode == `CDL_MODE_ONE) begin
                pins_next[0] = test_reg[`CDL_TEST_VAL_BIT];
            end else if (mode == `CDL_MODE_FOUR) begin
                pins_next = {4{test_reg[`CDL_TEST_VAL_BIT]}};
            end
        end else if (ext_mode) begin
            pins_next = {2'h0, sdata_reg, sclk_reg};
        end else if (showing_reg) begin
            if (mode == `CDL_MODE_ONE) begin
                pins_next[0] = (cs_cnt_reg < single_lim);
            end else if (mode == `CDL_MODE_FOUR) begin
                pins_next[0] = (snap_reg > 7'h00);
                pins_next[1] = (snap_reg > 7'h19);
                pins_next[2] = (snap_reg > 7'h32);
                pins_next[3] = (snap_reg > 7'h4B);
            end
        end
    end

    // ==================================================================
    // External shift chain driver
    always @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            sh_state_reg <= SH_IDLE;
            half_cnt_reg <= 32'h00000000;
            idx_reg <= 4'h0;
            sh_pat_reg <= 16'h0000;
            shifted_reg <= 16'h0000;
            sclk_reg <= 1'b0;
            sdata_reg <= 1'b0;
        end else begin
            case (sh_state_reg)
                SH_IDLE: begin
                    sclk_reg <= 1'b0;
                    if (ext_mode && want_pat != shifted_reg) begin
                        sh_pat_reg <= want_pat;
                        idx_reg <= led_n[3:0] - 4'h1;
                        sdata_reg <= want_pat[led_n[3:0] - 4'h1];
                        half_cnt_reg <= 32'h00000000;
                        sh_state_reg <= SH_LOW;
                    end
                end
                SH_LOW: begin
                    if (half_cnt_reg == SHIFT_HALF - 1) begin
                        sclk_reg <= 1'b1;
                        half_cnt_reg <= 32'h00000000;
                        sh_state_reg <= SH_HIGH;
                    end else begin
                        half_cnt_reg <= half_cnt_reg + 32'h1;
                    end
                end
                SH_HIGH: begin
                    if (half_cnt_reg == SHIFT_HALF - 1) begin
                        sclk_reg <= 1'b0;
                        half_cnt_reg <= 32'h00000000;
                        if (idx_reg == 4'h0) begin
                            shifted_reg <= sh_pat_reg;
                            sh_state_reg <= SH_IDLE;
                        end else begin
                            idx_reg <= idx_reg - 4'h1;
                            sdata_reg <= sh_pat_reg[idx_reg - 4'h1];
                            sh_state_reg <= SH_LOW;
                        end
                    end else begin
                        half_cnt_reg <= half_cnt_reg + 32'h1;
                    end
                end
                default: sh_state_reg <= SH_IDLE;
            endcase
        end
    end

    // ==================================================================
    // Output pins
    always @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            port_c_bit2_out <= 1'b0;
            port_c_bit0_out <= 1'b0;
            port_a_bit1_out <= 1'b0;
            port_a_bit2_out <= 1'b0;
        end else begin
            port_c_bit2_out <= pins_next[0];
            port_c_bit0_out <= pins_next[1];
            port_a_bit1_out <= pins_next[2];
            port_a_bit2_out <= pins_next[3];
        end
    end
endmodule

// ==== cdl_display_properties.sv ====
// Purpose: Port level assertions for the charge display block.
// Assumes: Zero wait state bus; config written while the link idles.
// Notes: CFG and TEST are shadowed from the writes seen on the bus.
`include "cdl_defines.vh"
module cdl_display_props #(parameter int SHIFT_HALF = 4) (
    input wire sys_clk,
    input wire arst_n,
    input wire hsel,
    input wire [31:0] haddr,
    input wire [1:0] htrans,
    input wire hwrite,
    input wire [31:0] hwdata,
    input wire hready,
    input wire port_c_bit2_out,
    input wire port_c_bit0_out,
    input wire port_a_bit1_out,
    input wire port_a_bit2_out
);
    timeunit 1ns;
    timeprecision 1ps;
    // ====================
    // Shadow registers and counters
    localparam int END = 2 * SHIFT_HALF + 2;
    logic wp_reg, c2_reg, frc_reg;
    logic [7:0] wa_reg, cfg_reg, q_reg, lo_reg, hi_reg, rc_reg;
    wire wd = wp_reg && hready;
    wire [2:0] md = cfg_reg[2:0];
    wire ext = md == `CDL_MODE_EXT_2W || md == `CDL_MODE_EXT_1W;
    wire [7:0] n = (cfg_reg[7:4] == 4'h0) ? 8'h01 : cfg_reg[7:4] + 8'h01;
    wire c2 = port_c_bit2_out;
    wire c0 = port_c_bit0_out;
    wire a1 = port_a_bit1_out;
    wire a2 = port_a_bit2_out;
    wire calm = q_reg == 8'h3F && !frc_reg;
    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            {wp_reg, c2_reg, frc_reg, wa_reg, cfg_reg} <= '0;
            {q_reg, lo_reg, hi_reg, rc_reg} <= '0;
        end else begin
            if (hready) begin
                wp_reg <= hsel && htrans[1] && hwrite;
                wa_reg <= haddr[7:0];
            end
            if (wd && wa_reg == `CDL_ADDR_CFG) cfg_reg <= hwdata[7:0];
            if (wd && wa_reg == `CDL_ADDR_TEST) frc_reg <= hwdata[0];
            q_reg <= wd ? 8'h00 : (q_reg == 8'h3F ? q_reg : q_reg + 8'h01);
            c2_reg <= c2;
            hi_reg <= c2 ? hi_reg + 8'h01 : 8'h00;
            lo_reg <= c2 ? 8'h00 : (lo_reg == 8'hFF ? lo_reg : lo_reg + 8'h01);
            // A rise after a low longer than one half period opens a burst.
            if (wd) rc_reg <= 8'h00;
            else if (ext && c2 && !c2_reg)
                rc_reg <= (lo_reg > SHIFT_HALF) ? 8'h01 : rc_reg + 8'h01;
        end
    end
    // ====================
    // Assertions
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!arst_n);
    quiet_mode_zero_a: assert property (
        md == `CDL_MODE_NONE && calm |-> !c2 && !c0 && !a1 && !a2)
        else $error("pins lit with display off");
    upper_pins_idle_a: assert property (
        md != `CDL_MODE_FOUR && q_reg == 8'h3F |-> !a1 && !a2)
        else $error("upper pins lit outside four pin mode");
    four_thermo_a: assert property (
        md == `CDL_MODE_FOUR && q_reg == 8'h3F
        |-> (!a2 || a1) && (!a1 || c0) && (!c0 || c2))
        else $error("four pin pattern has a gap");
    single_pins_a: assert property (
        md == `CDL_MODE_ONE && calm |-> !c0 && !a1 && !a2)
        else $error("extra pins lit in one pin mode");
    data_setup_a: assert property (
        ext && $rose(c2) |-> $stable(c0) ##1 $stable(c0))
        else $error("shift data moved around clock rise");
    high_len_a: assert property (
        ext && $fell(c2) |-> hi_reg == SHIFT_HALF)
        else $error("shift clock high time wrong");
    low_len_a: assert property (
        ext && $rose(c2) |-> lo_reg >= SHIFT_HALF)
        else $error("shift clock low time short");
    bit_count_a: assert property (
        ext && lo_reg == END && rc_reg != 8'h00 |-> rc_reg == n)
        else $error("shift burst length wrong");
    burst_split_a: assert property (
        ext && $rose(c2) && lo_reg > SHIFT_HALF && rc_reg != 8'h00
        |-> rc_reg == n)
        else $error("shift burst length wrong before next burst");
endmodule
bind cdl_display cdl_display_props #(.SHIFT_HALF(SHIFT_HALF)) u_props (
    .sys_clk(sys_clk), .arst_n(arst_n), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hwdata(hwdata), .hready(hready),
    .port_c_bit2_out(port_c_bit2_out), .port_c_bit0_out(port_c_bit0_out),
    .port_a_bit1_out(port_a_bit1_out), .port_a_bit2_out(port_a_bit2_out));

// ==== cdl_chain_model.sv ====
// Purpose: Model of the external serial-in parallel-out LED chain.
// Assumes: Two cascaded eight-bit stages that capture on rising clock.
// Notes: Bit 0 is the LED nearest the data input.
module cdl_chain_model (
    input wire sclk,
    input wire sdata,
    output logic [15:0] leds
);
    timeunit 1ns;
    timeprecision 1ps;
    initial leds = 16'h0000;
    // One bit enters per rising clock; outputs hold between bursts.
    always @(posedge sclk) begin
        leds <= {leds[14:0], sdata};
    end
endmodule

// ==== testbench.sv ====
// Purpose: Self-checking bench for the charge level display.
// Assumes: Zero wait state register bus, short tick in simulation.
// Notes: Shift, four pin and register read cases run from tables, the rest are hand written.
`include "cdl_defines.vh"
module testbench;
    timeunit 1ns;
    timeprecision 1ps;
    localparam int HALF = 4;
    logic sys_clk = 1'b0;
    logic arst_n = 1'b0;
    logic hsel = 1'b0;
    logic [31:0] haddr = 32'h0;
    logic [1:0] htrans = 2'h0;
    logic hwrite = 1'b0;
    logic [2:0] hsize = 3'h2;
    logic [31:0] hwdata = 32'h0;
    logic sense = 1'b0;
    logic [31:0] rd;
    int n_fail = 0;
    int checks_done = 0;
    int cnt;
    wire hready;
    wire [31:0] hrdata;
    wire hresp, c2, c0, a1, a2;
    wire [15:0] leds;
    wire [19:0] view = {leds, a2, a1, c0, c2};
    logic [7:0] r_cfg [6] = '{8'h13, 8'h73, 8'hF4, 8'h83, 8'h03, 8'h94};
    logic [7:0] r_chg [6] = '{8'h32, 8'h43, 8'h64, 8'h01, 8'h1E, 8'h78};
    logic [15:0] r_exp [6] = '{16'h1, 16'h3F, 16'hFFFF, 16'h1, 16'h1, 16'h3FF};
    logic [15:0] r_msk [6] = '{16'h3, 16'hFF, 16'hFFFF, 16'h1FF, 16'h1,
                               16'h3FF};
    logic [7:0] f_chg [4] = '{8'h00, 8'h19, 8'h43, 8'h64};
    logic [3:0] f_exp [4] = '{4'h0, 4'h1, 4'h7, 4'hF};
    logic [7:0] g_adr [5] = '{8'h00, 8'h04, 8'h08, 8'h0C, 8'h20};
    logic [7:0] g_exp [5] = '{8'h00, 8'h00, 8'h04, 8'h00, 8'h00};
    cdl_display #(.TICK_CYC(10), .SHIFT_HALF(HALF)) uut (
        .sys_clk(sys_clk), .arst_n(arst_n), .hsel(hsel), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
        .hready(hready), .hreadyout(hready), .hrdata(hrdata), .hresp(hresp),
        .display_request_sense(sense), .port_c_bit2_out(c2),
        .port_c_bit0_out(c0), .port_a_bit1_out(a1), .port_a_bit2_out(a2));
    cdl_chain_model chain (.sclk(c2), .sdata(c0), .leds(leds));
    // ====================
    // Tasks
    task automatic complete_run;
        $display("checks %0d failures %0d", checks_done, n_fail);
        if (n_fail == 0 && checks_done > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask
    task automatic check(input string what, input logic [31:0] exp,
                         input logic [31:0] got);
        checks_done++;
        if (got !== exp) begin
            n_fail++;
            $display("wrong value %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic wait_val(input logic [19:0] m, input logic [19:0] v,
                            input int lim);
        cnt = 0;
        while ((view & m) !== v) begin
            @(posedge sys_clk);
            cnt++;
            if (cnt > lim) begin
                check("timeout", 32'h1, 32'h0);
                complete_run();
            end
        end
    endtask
    task automatic wait_ready;
        int k;
        k = 0;
        do begin
            @(posedge sys_clk);
            k++;
        end while (hready !== 1'b1 && k < 50);
        if (hready !== 1'b1) begin
            check("hready", 32'h1, 32'h0);
            complete_run();
        end
    endtask
    task automatic bus(input logic w, input logic [7:0] a,
                       input logic [31:0] wd);
        @(posedge sys_clk);
        hsel <= 1'b1;
        haddr <= {24'h0, a};
        htrans <= 2'h2;
        hwrite <= w;
        wait_ready();
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= wd;
        wait_ready();
        rd = hrdata;
    endtask
    // ====================
    // Stimulus
    initial begin
        forever #4 sys_clk = ~sys_clk;
    end
    initial begin
        repeat (8) @(posedge sys_clk);
        arst_n <= 1'b1;
        bus(1'b1, `CDL_ADDR_HOLD, 32'h1);
        for (int r = 0; r < 6; r++) begin
            bus(1'b1, `CDL_ADDR_CHARGE, {24'h0, r_chg[r]});
            bus(1'b1, `CDL_ADDR_CFG, {24'h0, r_cfg[r]});
            sense <= 1'b1;
            wait_val(20'h1, 20'h1, 2100);
            check("hold", 32'h1, {31'h0, cnt >= 1000 && cnt <= 2000});
            repeat (2 * HALF * 17 + 4) @(posedge sys_clk);
            check("chain", 32'(r_exp[r]), 32'(leds & r_msk[r]));
            sense <= 1'b0;
            wait_val({r_msk[r], 4'h0}, 20'h0, 1300);
        end
        bus(1'b0, `CDL_ADDR_CHARGE, 32'h0);
        check("charge", 32'h64, rd);
        // The snapshot is only refreshed once per hold period (one second here) while always on.
        for (int f = 0; f < 4; f++) begin
            bus(1'b1, `CDL_ADDR_CFG, 32'h0);
            bus(1'b1, `CDL_ADDR_CHARGE, {24'h0, f_chg[f]});
            bus(1'b1, `CDL_ADDR_CFG, 32'h0A);
            wait_val(20'hF, {16'h0, f_exp[f]}, 1100);
            check("four", {28'h0, f_exp[f]}, {28'h0, view[3:0]});
        end
        bus(1'b1, `CDL_ADDR_CHARGE, 32'h19);
        repeat (5) @(posedge sys_clk);
        check("snapshot", 32'hF, {28'h0, view[3:0]});
        wait_val(20'hF, 20'h1, 1100);
        bus(1'b1, `CDL_ADDR_CFG, 32'h0);
        repeat (70) @(posedge sys_clk);
        bus(1'b1, `CDL_ADDR_CFG, 32'h33);
        bus(1'b1, `CDL_ADDR_TEST, 32'h3);
        repeat (150) @(posedge sys_clk);
        check("force on", 32'hF, {28'h0, leds[3:0]});
        bus(1'b1, `CDL_ADDR_TEST, 32'h1);
        repeat (150) @(posedge sys_clk);
        check("force off", 32'h0, {28'h0, leds[3:0]});
        bus(1'b1, `CDL_ADDR_TEST, 32'h0);
        bus(1'b1, `CDL_ADDR_HOLD, 32'h3);
        bus(1'b1, `CDL_ADDR_CHARGE, 32'h5F);
        bus(1'b1, `CDL_ADDR_CFG, 32'h09);
        // Let the display left over from always on run out its hold time.
        repeat (3100) @(posedge sys_clk);
        check("one idle", 32'h0, {31'h0, c2});
        bus(1'b0, `CDL_ADDR_STATUS, 32'h0);
        check("showing", 32'h0, {31'h0, rd[0]});
        sense <= 1'b1;
        wait_val(20'h1, 20'h1, 2100);
        sense <= 1'b0;
        wait_val(20'h1, 20'h0, 1100);
        wait_val(20'h1, 20'h1, 1100);
        wait_val(20'h1, 20'h0, 1100);
        check("on time", 32'h1, {31'h0, cnt >= 895 && cnt <= 905});
        bus(1'b1, `CDL_ADDR_CFG, 32'h0);
        sense <= 1'b1;
        repeat (2000) @(posedge sys_clk);
        check("mode off", 32'h0, {28'h0, view[3:0]});
        sense <= 1'b0;
        arst_n <= 1'b0;
        repeat (8) @(posedge sys_clk);
        arst_n <= 1'b1;
        bus(1'b1, 8'h20, 32'hFF);
        for (int g = 0; g < 5; g++) begin
            bus(1'b0, g_adr[g], 32'h0);
            check("reg", {24'h0, g_exp[g]}, rd);
            check("resp", 32'h0, {31'h0, hresp});
        end
        complete_run();
    end
endmodule
